/* File: core/tacio_pkg.sv */
// Package: constants, types and timing for the turnstile access-control I/O
package tacio_pkg;

   // System clock and millisecond tick
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned TICK_MS_HZ     = 1_000;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / TICK_MS_HZ;
   // Least command hold in pulse control, in ms
   localparam int unsigned CMD_MIN_MS     = 100;
   // Debounce length in ms ticks; must stay below the command hold
   localparam int unsigned DEB_MS         = 20;
   // Passage guard in ms; the passage decoder never reads it, so a half-done rotation is never abandoned
   localparam int unsigned ROT_TIMEOUT_MS = 3_000;
   // Reset values
   localparam logic        RST_LOW        = 1'b0;

   // Operating modes
   typedef enum logic [2:0] {
      TACIO_LOCKED      = 3'b000,
      TACIO_SINGLE_ONE  = 3'b001,
      TACIO_SINGLE_BOTH = 3'b010,
      TACIO_FREE_ONE    = 3'b011,
      TACIO_FREE_SINGLE = 3'b100,
      TACIO_FREE_ALL    = 3'b101
   } tacio_mode_t;

   // Passage decoder states
   typedef enum logic [1:0] {
      TACIO_ROT_IDLE  = 2'b00,
      TACIO_ROT_RIGHT = 2'b01,
      TACIO_ROT_LEFT  = 2'b10
   } tacio_rot_t;

   // Cleaned command and sensor inputs, active high
   typedef struct packed {
      logic right;
      logic stop;
      logic left;
      logic sens_a;
      logic sens_b;
   } tacio_in_t;

   // Per-direction permission
   typedef struct packed {
      logic right;
      logic left;
   } tacio_dir_t;

endpackage

/* File: core/tacio_filter.sv */
// Module: three-flop synchroniser and ms-tick debouncer for one input
`timescale 1ns/100ps
module tacio_filter #(
   parameter int unsigned DEB_TICKS = 20
) (
   input  wire logic I_CLK_SYS,
   input  wire logic I_RESET,
   input  wire logic i_tick,
   input  wire logic i_pin,
   output logic      o_level
);
   localparam int CW = $clog2(DEB_TICKS + 1);
   logic [2:0]    sync_reg;
   logic [CW-1:0] cnt_reg;
   logic          level_reg;
   // Stage 1 is read only by stage 2; stages 2 and 3 must agree
   wire           agree  = (sync_reg[1] == sync_reg[2]);
   wire           differ = agree && (sync_reg[2] != level_reg);
   wire           done   = (cnt_reg == CW'(DEB_TICKS - 1));

   // Synchroniser chain, reset to the released (high) pin level
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) sync_reg <= 3'h7;
      else         sync_reg <= {sync_reg[1:0], i_pin};
   end

   // New level must hold for DEB_TICKS ms ticks before it counts
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET || !differ) begin
         cnt_reg <= '0;
      end else if (i_tick) begin
         cnt_reg <= done ? '0 : cnt_reg + CW'(1);
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET)                    level_reg <= 1'b1;
      else if (differ && i_tick && done) level_reg <= sync_reg[2];
   end

   assign o_level = level_reg;
endmodule // tacio_filter

/* File: core/tacio_top.sv */
// Module: turnstile access-control discrete I/O core
`timescale 1ns/100ps
module tacio_top #(
   parameter int unsigned DEB_MS     = tacio_pkg::DEB_MS,
   parameter int unsigned CYC_PER_MS = tacio_pkg::CYC_PER_MS
) (
   input  wire logic              I_CLK_SYS,
   input  wire logic              I_RESET,
   input  wire logic              i_right_cmd_n,
   input  wire logic              i_stop_cmd_n,
   input  wire logic              i_left_cmd_n,
   input  wire logic              i_control_style_jumper_n,
   input  wire logic              i_rot_sensor_a_n,
   input  wire logic              i_rot_sensor_b_n,
   input  wire logic              i_mains_ok,
   input  wire logic              i_battery_low,
   input  wire logic              i_intrusion,
   input  wire tacio_pkg::tacio_mode_t i_panel_mode,
   input  wire logic              i_panel_dir_left,
   input  wire logic              i_panel_load,
   output logic                   O_PASS_RIGHT_OPEN,
   output logic                   O_PASS_LEFT_OPEN,
   output logic                   O_MAINS_FAIL_XSTR_ON,
   output logic                   O_BAT_FAIL_XSTR_ON,
   output logic                   O_INTRUSION_RELAY,
   output logic                   O_DENY_LEFT_INDICATOR,
   output logic                   O_ALLOW_LEFT_INDICATOR,
   output logic                   O_DENY_RIGHT_INDICATOR,
   output logic                   O_ALLOW_RIGHT_INDICATOR,
   output tacio_pkg::tacio_mode_t O_MODE,
   output logic                   O_PULSE_CONTROL
);
   localparam int TW = $clog2(CYC_PER_MS);

   // Millisecond tick divider
   logic [TW-1:0] div_reg;
   logic          tick_reg;
   wire           div_end = (div_reg == TW'(CYC_PER_MS - 1));
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) div_reg <= '0;
      else         div_reg <= div_end ? '0 : div_reg + TW'(1);
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) tick_reg <= 1'b0;
      else         tick_reg <= div_end;
   end

   // Clean every pin input before use
   logic [5:0] pin_raw;
   logic [5:0] pin_clean;
   assign pin_raw = {i_right_cmd_n, i_stop_cmd_n, i_left_cmd_n,
                     i_rot_sensor_a_n, i_rot_sensor_b_n,
                     ~i_control_style_jumper_n};
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_filt
         tacio_filter #(.DEB_TICKS(DEB_MS)) u_filt (
            .I_CLK_SYS (I_CLK_SYS),
            .I_RESET   (I_RESET),
            .i_tick    (tick_reg),
            .i_pin     (pin_raw[g]),
            .o_level   (pin_clean[g])
         );
      end
   endgenerate

   tacio_pkg::tacio_in_t in_c;
   assign in_c = ~pin_clean[5:1];
   // Jumper enters inverted: the filter's reset level reads as fitted,
   // so pulse control holds until a missing jumper is debounced
   wire jumper_fitted = pin_clean[0];

   // Control style: pulse until the filtered jumper says otherwise,
   // matching the delivered default
   logic pulse_reg;
   logic strap_seen_reg;
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         pulse_reg      <= 1'b1;
         strap_seen_reg <= 1'b0;
      end else begin
         strap_seen_reg <= 1'b1;
         if (strap_seen_reg) pulse_reg <= jumper_fitted;
      end
   end

   // Edge detect commands on cleaned levels
   logic [2:0] cmd_d_reg;
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) cmd_d_reg <= 3'h0;
      else         cmd_d_reg <= {in_c.right, in_c.stop, in_c.left};
   end
   // Debounce shorter than 100 ms lets a legal pulse register
   wire rise_r = in_c.right & ~cmd_d_reg[2];
   wire rise_s = in_c.stop  & ~cmd_d_reg[1];
   wire rise_l = in_c.left  & ~cmd_d_reg[0];

   // Mode and direction state
   tacio_pkg::tacio_mode_t mode_reg, mode_next;
   tacio_pkg::tacio_dir_t  allow_reg, allow_next;
   logic pass_done_r, pass_done_l;

   // Pulse: stop locks, right/left unblock one passage; a second
   // pulse in the other direction widens to both
   // Potential: permission follows held levels
   always_comb begin
      mode_next  = mode_reg;
      allow_next = allow_reg;
      if (pulse_reg) begin
         if (rise_s) begin
            mode_next  = tacio_pkg::TACIO_LOCKED;
            allow_next = '0;
         end else if (rise_r || rise_l || pass_done_r || pass_done_l) begin
            // Only events re-derive the mode, so loaded free modes hold; a passage not kept drops TACIO_FREE_SINGLE to TACIO_FREE_ONE
            if (rise_r) allow_next.right = 1'b1;
            if (rise_l) allow_next.left  = 1'b1;
            if (pass_done_r && !rise_r) allow_next.right = 1'b0;
            if (pass_done_l && !rise_l) allow_next.left  = 1'b0;
            mode_next = (allow_next.right && allow_next.left) ?
                        tacio_pkg::TACIO_SINGLE_BOTH :
                        (allow_next.right || allow_next.left) ?
                        tacio_pkg::TACIO_SINGLE_ONE :
                        tacio_pkg::TACIO_LOCKED;
            if ((mode_reg == tacio_pkg::TACIO_FREE_SINGLE) && !rise_r &&
                !rise_l) mode_next = tacio_pkg::TACIO_FREE_ONE;
         end
         // Panel may load any of the six modes
         if (i_panel_load) begin
            mode_next = i_panel_mode;
            unique case (i_panel_mode)
               tacio_pkg::TACIO_LOCKED:      allow_next = '0;
               tacio_pkg::TACIO_SINGLE_ONE,
               tacio_pkg::TACIO_FREE_ONE:
                  allow_next = {~i_panel_dir_left, i_panel_dir_left};
               tacio_pkg::TACIO_SINGLE_BOTH,
               tacio_pkg::TACIO_FREE_SINGLE,
               tacio_pkg::TACIO_FREE_ALL:    allow_next = 2'h3;
               default: begin
                  mode_next  = mode_reg;
                  allow_next = allow_reg;
               end
            endcase
         end
      end else begin
         allow_next = {in_c.right, in_c.left};
         mode_next  = (in_c.right && in_c.left) ?
                      tacio_pkg::TACIO_FREE_ALL :
                      (in_c.right || in_c.left) ?
                      tacio_pkg::TACIO_FREE_ONE :
                      tacio_pkg::TACIO_LOCKED;
      end
   end

   // Free modes keep the permission after a passage; TACIO_FREE_SINGLE only in the direction set by i_panel_dir_left
   wire keep_r = (mode_reg == tacio_pkg::TACIO_FREE_ALL) ||
                 (mode_reg == tacio_pkg::TACIO_FREE_ONE) ||
                 ((mode_reg == tacio_pkg::TACIO_FREE_SINGLE) &&
                  !i_panel_dir_left);
   wire keep_l = (mode_reg == tacio_pkg::TACIO_FREE_ALL) ||
                 (mode_reg == tacio_pkg::TACIO_FREE_ONE) ||
                 ((mode_reg == tacio_pkg::TACIO_FREE_SINGLE) &&
                  i_panel_dir_left);

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         mode_reg  <= tacio_pkg::TACIO_LOCKED;
         allow_reg <= '0;
      end else begin
         mode_reg  <= mode_next;
         allow_reg <= allow_next;
      end
   end

   // Passage decoder: first sensor to operate fixes direction
   tacio_pkg::tacio_rot_t rot_reg, rot_next;
   wire any_sens = in_c.sens_a | in_c.sens_b;
   always_comb begin
      rot_next = rot_reg;
      unique case (rot_reg)
         tacio_pkg::TACIO_ROT_IDLE: begin
            if (in_c.sens_a && !in_c.sens_b)
               rot_next = tacio_pkg::TACIO_ROT_RIGHT;
            else if (in_c.sens_b && !in_c.sens_a)
               rot_next = tacio_pkg::TACIO_ROT_LEFT;
         end
         tacio_pkg::TACIO_ROT_RIGHT,
         tacio_pkg::TACIO_ROT_LEFT: begin
            if (!any_sens) rot_next = tacio_pkg::TACIO_ROT_IDLE;
         end
         default: rot_next = tacio_pkg::TACIO_ROT_IDLE;
      endcase
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) rot_reg <= tacio_pkg::TACIO_ROT_IDLE;
      else         rot_reg <= rot_next;
   end
   // Passage ends when the sensors release; single passes then expire
   wire rot_end = (rot_reg != tacio_pkg::TACIO_ROT_IDLE) && !any_sens;
   assign pass_done_r = rot_end && (rot_reg == tacio_pkg::TACIO_ROT_RIGHT)
                        && !keep_r;
   assign pass_done_l = rot_end && (rot_reg == tacio_pkg::TACIO_ROT_LEFT)
                        && !keep_l;

   // Registered outputs
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_PASS_RIGHT_OPEN       <= 1'b0;
         O_PASS_LEFT_OPEN        <= 1'b0;
         O_MAINS_FAIL_XSTR_ON    <= 1'b0;
         O_BAT_FAIL_XSTR_ON      <= 1'b0;
         O_INTRUSION_RELAY       <= 1'b0;
         O_DENY_LEFT_INDICATOR   <= 1'b1;
         O_ALLOW_LEFT_INDICATOR  <= 1'b0;
         O_DENY_RIGHT_INDICATOR  <= 1'b1;
         O_ALLOW_RIGHT_INDICATOR <= 1'b0;
         O_MODE                  <= tacio_pkg::TACIO_LOCKED;
         O_PULSE_CONTROL         <= 1'b1;
      end else begin
         // Contacts open for as long as the wing turns
         O_PASS_RIGHT_OPEN <= (rot_next == tacio_pkg::TACIO_ROT_RIGHT);
         O_PASS_LEFT_OPEN  <= (rot_next == tacio_pkg::TACIO_ROT_LEFT);
         // Status levels are same-domain supervisor outputs
         O_MAINS_FAIL_XSTR_ON    <= i_mains_ok;
         O_BAT_FAIL_XSTR_ON      <= ~i_battery_low;
         O_INTRUSION_RELAY       <= i_intrusion;
         O_DENY_LEFT_INDICATOR   <= ~allow_next.left;
         O_ALLOW_LEFT_INDICATOR  <= allow_next.left;
         O_DENY_RIGHT_INDICATOR  <= ~allow_next.right;
         O_ALLOW_RIGHT_INDICATOR <= allow_next.right;
         O_MODE                  <= mode_next;
         O_PULSE_CONTROL         <= pulse_reg;
      end
   end

   // Assertions
   AST_STOP_LOCKS: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) (pulse_reg && rise_s && !i_panel_load) |=>
      (O_MODE == tacio_pkg::TACIO_LOCKED) && O_DENY_LEFT_INDICATOR &&
      O_DENY_RIGHT_INDICATOR)
      else $error("stop did not lock");
   AST_PULSE_RIGHT: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) (pulse_reg && rise_r && !rise_s &&
      !i_panel_load) |=>
      O_ALLOW_RIGHT_INDICATOR)
      else $error("right pulse not taken");
   AST_POT_FOLLOW: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) !pulse_reg |=>
      (O_ALLOW_LEFT_INDICATOR == $past(in_c.left)))
      else $error("potential left not followed");
   AST_POT_NO_STOP: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) (!pulse_reg && in_c.right) |=>
      O_ALLOW_RIGHT_INDICATOR)
      else $error("stop acted in potential");
   AST_STYLE: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) strap_seen_reg |=>
      (pulse_reg == $past(jumper_fitted)))
      else $error("style not from jumper");
   AST_DIR: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) (rot_reg == tacio_pkg::TACIO_ROT_IDLE &&
      in_c.sens_a && !in_c.sens_b) |=> O_PASS_RIGHT_OPEN && !O_PASS_LEFT_OPEN)
      else $error("direction wrong");
   AST_CONTACT_CLOSE: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) rot_end |=> !O_PASS_RIGHT_OPEN &&
      !O_PASS_LEFT_OPEN)
      else $error("contact stuck open");
   AST_MAINS: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) !i_mains_ok |=> !O_MAINS_FAIL_XSTR_ON)
      else $error("mains transistor on");
   AST_BAT: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) i_battery_low |=> !O_BAT_FAIL_XSTR_ON)
      else $error("battery transistor on");
   AST_IND_EXCL: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET)
      O_DENY_RIGHT_INDICATOR != O_ALLOW_RIGHT_INDICATOR)
      else $error("right indicator clash");
endmodule // tacio_top

/* File: verification/tacio_acs_model.sv */
// Access controller model: drives the three command contacts
`timescale 1ns/100ps
module tacio_acs_model #(
   parameter int unsigned HOLD_CYC = 1000
) (
   input  wire logic       i_clk,
   input  wire logic       i_go,
   input  wire logic [1:0] i_sel,
   input  wire logic [2:0] i_lvl,
   output logic [2:0]      o_cmd_n
);
   int unsigned cnt_reg = 0;
   logic [2:0]  pul_reg = 3'h0;

   // A pulse is held for the least command time, never shorter
   always_ff @(posedge i_clk) begin
      if (i_go) begin
         cnt_reg <= HOLD_CYC;
         pul_reg <= 3'h1 << i_sel;
      end else if (cnt_reg != 0) begin
         cnt_reg <= cnt_reg - 1;
      end else begin
         pul_reg <= 3'h0;
      end
   end

   // Open contact reads high; level control holds it closed while asked
   assign o_cmd_n = ~(pul_reg | i_lvl);
endmodule // tacio_acs_model

/* File: verification/test_turnstile_access_control_io.sv */
// Testbench: pulse and level control, passages and status outputs
`timescale 1ns/100ps
module test_turnstile_access_control_io;
   localparam int unsigned CPM  = 10;
   localparam int unsigned HOLD = tacio_pkg::CMD_MIN_MS * CPM;
   logic                   clk    = 1'b0;
   logic                   rst    = 1'b1;
   logic                   go     = 1'b0;
   logic [1:0]             sel    = 2'h0;
   logic [2:0]             lvl    = 3'h0;
   logic [2:0]             cmd_n;
   logic                   jmp_n  = 1'b0;
   logic                   sa_n   = 1'b1;
   logic                   sb_n   = 1'b1;
   logic                   mains  = 1'b1;
   logic                   batlow = 1'b0;
   logic                   intr   = 1'b0;
   logic                   pdir   = 1'b0;
   logic                   pload  = 1'b0;
   tacio_pkg::tacio_mode_t pmode  = tacio_pkg::TACIO_LOCKED;
   tacio_pkg::tacio_mode_t mode;
   logic pr, pl, mf, bf, ir, dl, al, dr, ar, pc;
   int err_total = 0;
   int checks = 0;

   // Half period of the 125 MHz clock
   always #4 clk = ~clk;

   tacio_acs_model #(.HOLD_CYC(HOLD)) i_acs (.i_clk(clk), .i_go(go),
      .i_sel(sel), .i_lvl(lvl), .o_cmd_n(cmd_n));

   // Short debounce and ms tick keep the run brief
   tacio_top #(.DEB_MS(2), .CYC_PER_MS(CPM)) i_dut (.I_CLK_SYS(clk),
      .I_RESET(rst), .i_right_cmd_n(cmd_n[0]), .i_stop_cmd_n(cmd_n[1]),
      .i_left_cmd_n(cmd_n[2]), .i_control_style_jumper_n(jmp_n),
      .i_rot_sensor_a_n(sa_n), .i_rot_sensor_b_n(sb_n),
      .i_mains_ok(mains), .i_battery_low(batlow), .i_intrusion(intr),
      .i_panel_mode(pmode), .i_panel_dir_left(pdir),
      .i_panel_load(pload), .O_PASS_RIGHT_OPEN(pr),
      .O_PASS_LEFT_OPEN(pl), .O_MAINS_FAIL_XSTR_ON(mf),
      .O_BAT_FAIL_XSTR_ON(bf), .O_INTRUSION_RELAY(ir),
      .O_DENY_LEFT_INDICATOR(dl), .O_ALLOW_LEFT_INDICATOR(al),
      .O_DENY_RIGHT_INDICATOR(dr), .O_ALLOW_RIGHT_INDICATOR(ar),
      .O_MODE(mode), .O_PULSE_CONTROL(pc));

   // Indicators expected from the permitted directions
   function automatic logic [7:0] ind(input logic r, input logic l);
      return {4'h0, ~l, l, ~r, r};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait for a mode; running out ends the run
   task automatic wait_mode(input tacio_pkg::tacio_mode_t m);
      int n = 0;
      while (mode !== m && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (mode !== m) begin
         check(8'(mode), 8'(m));
         test_done();
      end
   endtask

   // Pulse, then wait out the release so the next one is seen apart
   task automatic pulse(input logic [1:0] s);
      @(negedge clk);
      go = 1'b1;
      sel = s;
      @(negedge clk);
      go = 1'b0;
      cyc(HOLD + 60);
   endtask

   task automatic ind_chk(input logic r, input logic l);
      check({4'h0, dl, al, dr, ar}, ind(r, l));
   endtask

   // Wing turn: first sensor, both, then release in the reverse order
   task automatic rotate(input logic a_first);
      sa_n = ~a_first;
      sb_n = a_first;
      cyc(60);
      sa_n = 1'b0;
      sb_n = 1'b0;
      cyc(60);
      check({6'h0, pr, pl}, a_first ? 8'h2 : 8'h1);
      sa_n = ~a_first;
      sb_n = a_first;
      cyc(60);
      sa_n = 1'b1;
      sb_n = 1'b1;
      cyc(60);
      check({6'h0, pr, pl}, 8'h0);
   endtask

   task automatic reboot();
      rst = 1'b1;
      cyc(16);
      rst = 1'b0;
      cyc(60);
   endtask

   // Main sequence
   initial begin
      void'($urandom(19));
      cyc(16);
      check(8'(mode), 8'h0);
      check({6'h0, pr, pl}, 8'h0);
      ind_chk(1'b0, 1'b0);
      rst = 1'b0;
      cyc(60);
      check({7'h0, pc}, 8'h1);
      repeat (30) begin
         mains = 1'($urandom);
         batlow = 1'($urandom);
         intr = 1'($urandom);
         cyc(1);
         check({5'h0, mf, bf, ir},
               {5'h0, mains, ~batlow, intr});
      end
      pulse(2'h0);
      wait_mode(tacio_pkg::TACIO_SINGLE_ONE);
      ind_chk(1'b1, 1'b0);
      rotate(1'b1);
      wait_mode(tacio_pkg::TACIO_LOCKED);
      ind_chk(1'b0, 1'b0);
      pulse(2'h2);
      wait_mode(tacio_pkg::TACIO_SINGLE_ONE);
      ind_chk(1'b0, 1'b1);
      rotate(1'b0);
      wait_mode(tacio_pkg::TACIO_LOCKED);
      pulse(2'h0);
      pulse(2'h2);
      wait_mode(tacio_pkg::TACIO_SINGLE_BOTH);
      ind_chk(1'b1, 1'b1);
      pulse(2'h1);
      wait_mode(tacio_pkg::TACIO_LOCKED);
      ind_chk(1'b0, 1'b0);
      // Every mode and back to locked through the panel
      for (int m = 1; m <= 6; m++) begin
         pmode = tacio_pkg::tacio_mode_t'(m % 6);
         pdir = 1'($urandom);
         pload = 1'b1;
         cyc(1);
         pload = 1'b0;
         cyc(2);
         check(8'(mode), 8'(m % 6));
      end
      // Jumper removed: level control after reset
      jmp_n = 1'b1;
      reboot();
      check({7'h0, pc}, 8'h0);
      pmode = tacio_pkg::TACIO_FREE_ALL;
      pload = 1'b1;
      cyc(1);
      pload = 1'b0;
      cyc(3);
      check(8'(mode), 8'h0);
      lvl = 3'h1;
      wait_mode(tacio_pkg::TACIO_FREE_ONE);
      ind_chk(1'b1, 1'b0);
      pulse(2'h1);
      check(8'(mode), 8'(tacio_pkg::TACIO_FREE_ONE));
      lvl = 3'h5;
      wait_mode(tacio_pkg::TACIO_FREE_ALL);
      ind_chk(1'b1, 1'b1);
      lvl = 3'h0;
      wait_mode(tacio_pkg::TACIO_LOCKED);
      ind_chk(1'b0, 1'b0);
      test_done();
   end
endmodule // test_turnstile_access_control_io
